// file: logic/flow_pkg.sv
// shared constants and types for the receive flow-control trigger
package flow_pkg;

  // register map
  localparam logic [31:0] CFG_ADDR    = 32'h0000_00AC;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_00C0;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [31:0] CFG_WMASK   = 32'h00FF_FFFF;

  // status bit positions
  localparam int ST_PAUSE_SENT = 0;
  localparam int ST_HIGH       = 1;
  localparam int ST_JAM        = 2;
  localparam int ST_BELOW_LOW  = 3;

  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;

  // fifo level units
  localparam int LEVEL_W     = 16;
  localparam int BLOCK_SHIFT = 6;

  // timing: jam durations counted in 100 ns ticks
  localparam int CLK_MHZ     = 100;
  localparam int TICK_NS     = 100;
  localparam int TICK_CYCLES = (TICK_NS * CLK_MHZ + 999) / 1000;
  localparam int TICK_W      = 4;
  localparam int DUR_W       = 13;

  // durations in tenths of a microsecond
  localparam int DUR_C0      = 50;
  localparam int DUR_C1      = 100;
  localparam int DUR_C2      = 150;
  localparam int DUR_C3      = 250;
  localparam int DUR_C4      = 500;
  localparam int DUR_C5      = 1000;
  localparam int DUR_STEP    = 500;
  localparam int DUR_SLOW    = 22;
  localparam int DUR_LINEAR  = 5;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_PAUSED = 2'b01,
    ST_JAMMING = 2'b10
  } flow_state_t;

  typedef struct packed {
    logic [7:0] reserved;
    logic [7:0] high_level;
    logic [7:0] low_level;
    logic [3:0] jam_duration_code;
    logic       select_multicast;
    logic       select_broadcast;
    logic       select_address_match;
    logic       select_any_frame;
  } cfg_t;

  typedef struct packed {
    logic frame_start;
    logic addr_valid;
    logic multicast;
    logic broadcast;
    logic addr_match;
  } frame_t;

  function automatic logic [LEVEL_W-1:0] blocks_to_bytes(input logic [7:0] blocks);
    return LEVEL_W'(blocks) << BLOCK_SHIFT;
  endfunction

endpackage

// file: logic/tick_divider.sv
// 100 ns enable pulse from the system clock, restartable
`timescale 1ns/1ns
`default_nettype none
module tick_divider (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic restart,
  output var  logic tick
);

  localparam logic [flow_pkg::TICK_W-1:0] LAST =
    flow_pkg::TICK_W'(flow_pkg::TICK_CYCLES - 1);

  logic [flow_pkg::TICK_W-1:0] count;
  wire                         wrap = (count == LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= (restart || wrap) ? '0 : count + 1'b1;
      tick  <= wrap && !restart;
    end
  end

endmodule
`default_nettype wire

// file: logic/jam_timer.sv
// backpressure duration timer loaded from the duration code
`timescale 1ns/1ns
`default_nettype none
module jam_timer (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic [3:0] code,
  input  wire logic       speed_100,
  // state
  output var  logic       busy
);

  logic [flow_pkg::DUR_W-1:0] remaining;

  function automatic logic [flow_pkg::DUR_W-1:0] duration(input logic [3:0] c,
                                                           input logic     fast);
    int base;
    base = 0;
    case (c)
      4'h0: base = flow_pkg::DUR_C0;
      4'h1: base = flow_pkg::DUR_C1;
      4'h2: base = flow_pkg::DUR_C2;
      4'h3: base = flow_pkg::DUR_C3;
      4'h4: base = flow_pkg::DUR_C4;
      default: base = flow_pkg::DUR_C5
                      + (int'(c) - flow_pkg::DUR_LINEAR) * flow_pkg::DUR_STEP;
    endcase
    if (!fast) begin
      base = base + flow_pkg::DUR_SLOW;
    end
    return flow_pkg::DUR_W'(base);
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      remaining <= '0;
    end else if (stop) begin
      remaining <= '0;
    end else if (start) begin
      remaining <= duration(code, speed_100);
    end else if (tick && remaining != '0) begin
      remaining <= remaining - 1'b1;
    end
  end

  assign busy = (remaining != '0);

endmodule
`default_nettype wire

// file: logic/rx_fifo_flow_control.sv
// receive fifo flow-control trigger with ahb-lite register slave
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - No pause frame or backpressure while the MAC transmitter is disabled.
// - High level, bits 23:16, in 64-byte units, triggers pause or backpressure.
// - Full duplex: one pause frame per high event, carrying the pause time.
// - Half duplex: jam each matching incoming frame for the programmed duration.
// - Low level, bits 15:8, 64-byte units; falling below sends zero-time pause.
// - Zero-time pause only after a high-level pause frame was sent.
// - Duration code, bits 7:4, sets jam length; unused in full duplex.
// - Codes map 5 us to 600 us at 100 Mb/s; 2.2 us longer at 10.
// - Multicast select, bit 3, jams multicast frames past the high level.
// - Broadcast select, bit 2, jams broadcast frames past the high level.
// - Address-match select, bit 1, jams frames for this station.
// - Any-frame select, bit 0, reacts on any frame; sole full-duplex enable.
// - Half duplex any-frame reacts on preamble without address decoding.
// - Full duplex any-frame requests a pause frame from the MAC immediately.
// - Any-frame select overrides the other three select bits.
module rx_fifo_flow_control (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,

  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,

  // mac status
  input  wire logic        tx_enabled,
  input  wire logic        full_duplex,
  input  wire logic        speed_100,
  input  wire logic [15:0] pause_time_value,

  // receive side
  input  wire logic [15:0] rx_fifo_level,
  input  wire logic        frame_start,
  input  wire logic        frame_addr_valid,
  input  wire logic        frame_multicast,
  input  wire logic        frame_broadcast,
  input  wire logic        frame_addr_match,

  // requests to the mac
  output var  logic        pause_request,
  output var  logic [15:0] pause_time,
  output var  logic        jam_active
);

  // address decode shared by reads and writes
  function automatic logic hits(input logic [31:0] addr,
                                input logic [31:0] target);
    return addr == target;
  endfunction

  // ---------------- register slave ----------------

  flow_pkg::cfg_t cfg;
  flow_pkg::frame_t frame;
  flow_pkg::flow_state_t state;
  flow_pkg::flow_state_t next_state;

  logic        dp_write;
  logic [31:0] dp_addr;

  wire addr_phase = hsel && hready
                    && (htrans == flow_pkg::HTRANS_NONSEQ
                        || htrans == flow_pkg::HTRANS_SEQ);
  wire write_cfg  = dp_write && hits(dp_addr, flow_pkg::CFG_ADDR);
  wire [31:0] cfg_written = hwdata & flow_pkg::CFG_WMASK;

  // forward a write still in its data phase to a following read
  wire [31:0] cfg_view = write_cfg ? cfg_written : 32'(cfg);

  // derived state, declared before the read mux uses it
  logic high_reached;
  logic below_low;
  logic jam_busy;

  wire [31:0] status_view = {28'h0000000,
                             below_low,
                             jam_active,
                             high_reached,
                             state == flow_pkg::ST_PAUSED};

  wire rd_cfg    = hits(haddr, flow_pkg::CFG_ADDR);
  wire rd_status = hits(haddr, flow_pkg::STATUS_ADDR);

  wire [31:0] read_value = rd_cfg    ? cfg_view :
                           rd_status ? status_view :
                           32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr  <= 32'h0000_0000;
    end else if (hready) begin
      dp_write <= addr_phase && hwrite;
      dp_addr  <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= read_value;
    end
  end

  // zero-wait slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= flow_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= flow_pkg::HRESP_OKAY;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= flow_pkg::cfg_t'(flow_pkg::CFG_RESET);
    end else if (write_cfg) begin
      cfg <= flow_pkg::cfg_t'(cfg_written);
    end
  end

  // ---------------- fifo level compare ----------------

  wire [15:0] high_bytes = flow_pkg::blocks_to_bytes(cfg.high_level);
  wire [15:0] low_bytes  = flow_pkg::blocks_to_bytes(cfg.low_level);

  assign high_reached = rx_fifo_level >= high_bytes;

  assign below_low    = rx_fifo_level < low_bytes;

  // ---------------- frame selection ----------------

  assign frame = '{frame_start:  frame_start,
                   addr_valid:   frame_addr_valid,
                   multicast:    frame_multicast,
                   broadcast:    frame_broadcast,
                   addr_match:   frame_addr_match};

  wire hit_multicast = cfg.select_multicast && frame.multicast;

  wire hit_broadcast = cfg.select_broadcast && frame.broadcast;

  wire hit_address   = cfg.select_address_match && frame.addr_match;

  wire selected_hit  = frame.addr_valid
                       && (hit_multicast || hit_broadcast || hit_address);

  // any-frame reacts on the preamble, no address decode
  wire any_hit       = frame.frame_start;

  wire hd_match      = cfg.select_any_frame ? any_hit : selected_hit;

  // only any-frame enables full-duplex flow control
  wire fd_enabled    = full_duplex && cfg.select_any_frame;

  // ---------------- trigger state machine ----------------

  logic        jam_start;
  logic        jam_stop;
  logic        send_pause;
  logic        send_zero;

  always_comb begin
    next_state = state;
    jam_start  = 1'b0;
    jam_stop   = 1'b0;
    send_pause = 1'b0;
    send_zero  = 1'b0;
    case (state)
      flow_pkg::ST_IDLE: begin
        // nothing while the transmitter is off
        if (tx_enabled && high_reached) begin
          if (fd_enabled) begin
            send_pause = 1'b1;
            next_state = flow_pkg::ST_PAUSED;
          end else if (!full_duplex && hd_match) begin
            jam_start  = 1'b1;
            next_state = flow_pkg::ST_JAMMING;
          end
        end
      end
      flow_pkg::ST_PAUSED: begin
        // release only after a sent pause
        if (!fd_enabled) begin
          next_state = flow_pkg::ST_IDLE;
        end else if (tx_enabled && below_low) begin
          send_zero  = 1'b1;
          next_state = flow_pkg::ST_IDLE;
        end
      end
      flow_pkg::ST_JAMMING: begin
        if (!tx_enabled || full_duplex) begin
          jam_stop   = 1'b1;
          next_state = flow_pkg::ST_IDLE;
        end else if (!jam_busy) begin
          next_state = flow_pkg::ST_IDLE;
        end
      end
      default: begin
        jam_stop   = 1'b1;
        next_state = flow_pkg::ST_IDLE;
      end
    endcase
  end

  // paused state is the sent-pause flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= flow_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ---------------- pause requests ----------------

  // one pause frame carrying the programmed time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pause_request <= 1'b0;
      pause_time    <= 16'h0000;
    end else begin
      pause_request <= send_pause || send_zero;
      if (send_pause) begin
        pause_time <= pause_time_value;
      end else if (send_zero) begin
        pause_time <= 16'h0000;
      end
    end
  end

  // ---------------- backpressure ----------------

  logic tick;

  tick_divider u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .restart (jam_start),
    .tick    (tick)
  );

  // duration from the code and link speed
  jam_timer u_timer (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .tick      (tick),
    .start     (jam_start),
    .stop      (jam_stop),
    .code      (cfg.jam_duration_code),
    .speed_100 (speed_100),
    .busy      (jam_busy)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jam_active <= 1'b0;
    end else begin
      jam_active <= jam_busy && tx_enabled && !full_duplex
                    && next_state == flow_pkg::ST_JAMMING;
    end
  end

  // hsize unused: every transfer is served as a whole word
  wire unused_ok = &{1'b0, hsize};

endmodule
`default_nettype wire

// file: verif/rx_fifo_flow_control_asserts.sv
// assertions on the flow-control trigger ports
`timescale 1ns/1ns
`default_nettype none
module rx_fifo_flow_control_asserts (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // watched ports
  input wire logic        tx_enabled,
  input wire logic        full_duplex,
  input wire logic [15:0] pause_time_value,
  input wire logic        pause_request,
  input wire logic [15:0] pause_time,
  input wire logic        jam_active
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic armed;
  // set by a timed pause, cleared by the zero pause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      armed <= 1'b0;
    else if (!full_duplex)
      armed <= 1'b0;
    else if (pause_request)
      armed <= pause_time != 16'h0000;
  end
  property p_pause_tx_off;
    !tx_enabled [*3] |-> !pause_request;
  endproperty
  a_pause_tx_off: assert property (p_pause_tx_off) else $error("pause, tx off");
  property p_jam_tx_off;
    !tx_enabled [*3] |-> !jam_active;
  endproperty
  a_jam_tx_off: assert property (p_jam_tx_off) else $error("jam, tx off");
  property p_pause_pulse;
    pause_request |=> !pause_request;
  endproperty
  a_pause_pulse: assert property (p_pause_pulse) else $error("pause too long");
  property p_time_held;
    !pause_request |-> $stable(pause_time);
  endproperty
  a_time_held: assert property (p_time_held) else $error("pause time moved");
  property p_time_value;
    pause_request && pause_time != 16'h0000 |-> pause_time == pause_time_value;
  endproperty
  a_time_value: assert property (p_time_value) else $error("bad pause time");
  property p_zero_armed;
    pause_request && pause_time == 16'h0000 |-> armed;
  endproperty
  a_zero_armed: assert property (p_zero_armed) else $error("zero pause unarmed");
  property p_one_per_event;
    pause_request && pause_time != 16'h0000 |-> !armed;
  endproperty
  a_one_per_event: assert property (p_one_per_event) else $error("second pause");
  property p_pause_fd;
    pause_request |-> $past(full_duplex);
  endproperty
  a_pause_fd: assert property (p_pause_fd) else $error("pause in half duplex");
  property p_jam_fd;
    full_duplex [*3] |-> !jam_active;
  endproperty
  a_jam_fd: assert property (p_jam_fd) else $error("jam in full duplex");
  property p_jam_start;
    $rose(jam_active) |-> $past(tx_enabled) && !$past(full_duplex);
  endproperty
  a_jam_start: assert property (p_jam_start) else $error("bad jam start");
endmodule
bind rx_fifo_flow_control rx_fifo_flow_control_asserts rx_fifo_flow_control_asserts_inst (
  .hclk, .hresetn, .tx_enabled, .full_duplex, .pause_time_value, .pause_request,
  .pause_time, .jam_active);
`default_nettype wire

// file: verif/link_partner.sv
// remote station: frames on request, counts pause frames
`timescale 1ns/1ns
`default_nettype none
module link_partner (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // bench request
  input  wire logic       send,
  input  wire logic [2:0] kind,
  // frame events
  output wire logic       frame_start,
  output wire logic       frame_addr_valid,
  output wire logic       frame_multicast,
  output wire logic       frame_broadcast,
  output wire logic       frame_addr_match,
  // pause frames
  input  wire logic       pause_request,
  output var  logic [7:0] pauses_seen
);
  logic [2:0] step;
  logic [2:0] held;
  logic [2:0] noise;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step <= 3'h0;
      held <= 3'h0;
      noise <= 3'h0;
      pauses_seen <= 8'h00;
    end else begin
      step <= send ? 3'h4 : step - {2'h0, step != 3'h0};
      held <= send ? kind : held;
      noise <= noise + 3'h5;
      pauses_seen <= pauses_seen + {7'h00, pause_request};
    end
  end
  assign frame_start = step == 3'h4;
  assign frame_addr_valid = step == 3'h1;
  // flags garbage outside address decode
  assign frame_multicast = frame_addr_valid ? held[2] : noise[0];
  assign frame_broadcast = frame_addr_valid ? held[1] : noise[1];
  assign frame_addr_match = frame_addr_valid ? held[0] : noise[2];
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the receive flow-control trigger
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        hclk, hresetn, hreadyout, hresp, pause_request, jam_active;
  logic        frame_start, frame_addr_valid, frame_multicast, frame_broadcast;
  logic        frame_addr_match;
  logic        hsel = 1'b1, hwrite = 1'b0, send = 1'b0, speed_100 = 1'b1;
  logic        tx_enabled = 1'b0, full_duplex = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, kind = 3'h0;
  logic [7:0]  pauses_seen;
  logic [15:0] pause_time_value, pause_time, rx_fifo_level = 16'h0000;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, wv;
  logic [12:0] row;
  int          fails = 0, checks_done = 0, cycles = 0;
  // row: select, frame kind, duration code, fast, jam expected
  logic [12:0] cases [6] = '{13'h0203, 13'h1107, 13'h088B, 13'h044D, 13'h1082, 13'h1E13};
  rx_fifo_flow_control rx_fifo_flow_control_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_enabled,
    .full_duplex, .speed_100, .pause_time_value, .rx_fifo_level, .frame_start,
    .frame_addr_valid, .frame_multicast, .frame_broadcast, .frame_addr_match,
    .pause_request, .pause_time, .jam_active);
  link_partner link_partner_inst (.hclk, .hresetn, .send, .kind, .frame_start,
    .frame_addr_valid, .frame_multicast, .frame_broadcast, .frame_addr_match,
    .pause_request, .pauses_seen);
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    htrans <= flow_pkg::HTRANS_NONSEQ;
    haddr <= addr;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    check({31'h0, hresp}, {31'h0, flow_pkg::HRESP_OKAY});
  endtask
  function automatic int jam_cycles(input logic [3:0] code, input logic fast);
    int base [5] = '{50, 100, 150, 250, 500};
    int t;
    t = (code < 4'h5) ? base[code] : 1000 + (int'(code) - 5) * 500;
    return (fast ? t : t + 22) * 10;
  endfunction
  task automatic jam_case(input logic [12:0] r);
    int n;
    int d;
    bus(1'b1, flow_pkg::CFG_ADDR, {16'h0004, 8'h02, r[5:2], r[12:9]});
    speed_100 <= r[1];
    kind <= r[8:6];
    send <= 1'b1;
    @(posedge hclk);
    send <= 1'b0;
    n = 0;
    while (jam_active !== 1'b1 && n < 12) begin
      @(posedge hclk);
      n++;
    end
    check({31'h0, jam_active}, {31'h0, r[0]});
    n = 0;
    while (jam_active === 1'b1 && n < 7000) begin
      @(posedge hclk);
      n++;
    end
    d = n - jam_cycles(r[5:2], r[1]);
    if (r[0])
      check({31'h0, d > -16 && d < 16}, 32'h1);
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(68));
    pause_time_value = 16'($urandom_range(65535, 1));
    hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, flow_pkg::CFG_ADDR, 32'h0);
    check(rd, flow_pkg::CFG_RESET);
    wv = $urandom();
    bus(1'b1, flow_pkg::CFG_ADDR, wv);
    bus(1'b0, flow_pkg::CFG_ADDR, 32'h0);
    check(rd, wv & flow_pkg::CFG_WMASK);
    bus(1'b1, 32'h0000_0100, wv);
    bus(1'b0, 32'h0000_0100, 32'h0);
    check(rd, 32'h0);
    tx_enabled <= 1'b1;
    full_duplex <= 1'b1;
    bus(1'b1, flow_pkg::CFG_ADDR, 32'h0004_0201);
    repeat (4) @(posedge hclk);
    check({24'h0, pauses_seen}, 32'h0);
    rx_fifo_level <= 16'h0100;
    repeat (6) @(posedge hclk);
    check({24'h0, pauses_seen}, 32'h1);
    check({16'h0, pause_time}, {16'h0, pause_time_value});
    bus(1'b0, flow_pkg::STATUS_ADDR, 32'h0);
    check(rd, (32'h1 << flow_pkg::ST_PAUSE_SENT) | (32'h1 << flow_pkg::ST_HIGH));
    rx_fifo_level <= 16'h0080;
    repeat (10) @(posedge hclk);
    check({24'h0, pauses_seen}, 32'h1);
    rx_fifo_level <= 16'h007F;
    repeat (6) @(posedge hclk);
    check({24'h0, pauses_seen}, 32'h2);
    check({16'h0, pause_time}, 32'h0);
    bus(1'b0, flow_pkg::STATUS_ADDR, 32'h0);
    check(rd, 32'h1 << flow_pkg::ST_BELOW_LOW);
    tx_enabled <= 1'b0;
    rx_fifo_level <= 16'($urandom_range(65535, 256));
    repeat (10) @(posedge hclk);
    check({24'h0, pauses_seen}, 32'h2);
    rx_fifo_level <= 16'h0000;
    tx_enabled <= 1'b1;
    bus(1'b1, flow_pkg::CFG_ADDR, 32'h0004_020E);
    rx_fifo_level <= 16'h0100;
    repeat (10) @(posedge hclk);
    check({24'h0, pauses_seen}, 32'h2);
    full_duplex <= 1'b0;
    for (int i = 0; i < 6; i++)
      jam_case(cases[i]);
    row[12:9] = 4'(1 << $urandom_range(3, 1));
    row[8:0] = {row[12:10], 4'($urandom_range(4, 0)), 1'($urandom_range(1, 0)), 1'b1};
    jam_case(row);
    tx_enabled <= 1'b0;
    jam_case(13'h0202);
    tx_enabled <= 1'b1;
    rx_fifo_level <= 16'h00FF;
    jam_case(13'h0202);
    end_of_test();
  end
endmodule
`default_nettype wire
